// ### rtl/qds_mem.sv
// memory end: samples link clocks, decodes commands, stores and returns bursts
`default_nettype none
module qds_mem #(
  parameter int CAL_CYC = qds_pkg::CAL_PERIOD,
  parameter int LOCK    = qds_pkg::LOCK_KCYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // link
  qds_if.mem        lnk,
  // user-side status
  output logic                     loop_locked,
  output logic [qds_pkg::IMP_W-1:0] drive_level
);
  localparam int DW = qds_pkg::DATA_W;
  localparam int AW = qds_pkg::ADDR_W;
  localparam int LW = qds_pkg::LANE_W;
  localparam int NL = qds_pkg::LANES;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [3:0] clk_s1;
  logic [3:0] clk_s2;
  logic [3:0] clk_d;
  logic [1:0] sel_s1;
  logic [1:0] sel_s2;
  logic [AW-1:0] a_s1;
  logic [AW-1:0] a_s2;
  logic [DW-1:0] d_s1;
  logic [DW-1:0] d_s2;
  logic [NL-1:0] m_s1;
  logic [NL-1:0] m_s2;
  logic          off_s1;
  logic          off_s2;
  logic          cal_s1;
  logic          cal_s2;

  // two flops on every pin before use
  always_ff @(posedge ref_clk) begin
    clk_s1 <= {lnk.c_n, lnk.c_p, lnk.k_n, lnk.k_p};
    clk_s2 <= clk_s1;
    sel_s1 <= {lnk.wr_sel_n, lnk.rd_sel_n};
    sel_s2 <= sel_s1;
    a_s1   <= lnk.addr_in;
    a_s2   <= a_s1;
    d_s1   <= lnk.wr_data_in;
    d_s2   <= d_s1;
    m_s1   <= lnk.lane_mask_n;
    m_s2   <= m_s1;
    off_s1 <= lnk.loop_en_n_off;
    off_s2 <= off_s1;
    cal_s1 <= lnk.drive_cal_pin;
    cal_s2 <= cal_s1;
  end

  // edge history from the second stage only; it follows the pins through
  // reset so that idle-high clocks give no false edge on release
  always_ff @(posedge ref_clk) begin
    clk_d <= clk_s2;
  end

  logic kp_r;
  logic kn_r;
  logic cp_r;
  logic cn_r;
  logic c_tied;
  logic out_p;
  logic out_n;
  assign kp_r   = clk_s2[0] && !clk_d[0];
  assign kn_r   = clk_s2[1] && !clk_d[1];
  assign cp_r   = clk_s2[2] && !clk_d[2];
  assign cn_r   = clk_s2[3] && !clk_d[3];
  assign c_tied = clk_s2[2] && clk_s2[3];
  assign out_p  = c_tied ? kp_r : cp_r;
  assign out_n  = c_tied ? kn_r : cn_r;

  // ---------------------------------------------------------------------------
  // clock loop lock tracking
  // ---------------------------------------------------------------------------
  logic [11:0] lock_cnt;
  logic [3:0]  idle_cnt;
  // loop restarts on disable low or a stalled input clock
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lock_cnt    <= 12'h000;
      idle_cnt    <= 4'h0;
      loop_locked <= 1'b0;
    end else begin
      if (kp_r || kn_r) idle_cnt <= 4'h0;
      else if (idle_cnt != 4'hF) idle_cnt <= idle_cnt + 4'h1;
      if (!off_s2) begin
        lock_cnt    <= 12'h000;
        loop_locked <= 1'b0;
        // a divided link clock spends the stop limit in one half period,
        // so only a half period that overruns it by a cycle is a stop
      end else if (idle_cnt > 4'(qds_pkg::STOP_CYC)) begin
        lock_cnt    <= 12'h000;
        loop_locked <= 1'b0;
      end else if (kp_r && !loop_locked) begin
        lock_cnt <= lock_cnt + 12'h001;
        if (lock_cnt == 12'(LOCK - 1)) loop_locked <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------------
  logic          last_rd;
  logic          last_wr;
  logic          rd_go;
  logic          wr_go;
  logic [AW-1:0] wr_addr;
  logic [1:0]    wr_beat;
  logic          wr_act;
  logic          wr_pend;
  logic [AW-1:0] wr_next;
  logic [DW-1:0] wr_data [qds_pkg::BEATS];
  logic [NL-1:0] wr_mask [qds_pkg::BEATS];
  logic [DW-1:0] store [(1 << AW) * qds_pkg::BEATS];

  assign rd_go = kp_r && !sel_s2[0] && !last_rd;
  assign wr_go = kp_r && !sel_s2[1] && sel_s2[0] && !last_wr;

  // previous-command memory; a deselect clears both
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      last_rd <= 1'b0;
      last_wr <= 1'b0;
    end else if (kp_r) begin
      last_rd <= rd_go;
      last_wr <= wr_go;
    end
  end

  // write beats alternate k rise then k-bar rise; a write taken while the
  // previous one still collects beats waits until that one is stored
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_act  <= 1'b0;
      wr_pend <= 1'b0;
      wr_beat <= 2'h0;
      wr_addr <= '0;
      wr_next <= '0;
    end else begin
      if (wr_go) begin
        wr_pend <= 1'b1;
        wr_next <= a_s2;
      end
      if (wr_act && ((wr_beat[0] == 1'b0) ? kp_r : kn_r)) begin
        wr_data[wr_beat] <= d_s2;
        wr_mask[wr_beat] <= m_s2;
        wr_beat <= wr_beat + 2'h1;
        if (wr_beat == 2'h3) wr_act <= 1'b0;
      end else if (!wr_act && wr_pend && !wr_go) begin
        wr_act  <= 1'b1;
        wr_pend <= 1'b0;
        wr_beat <= 2'h0;
        wr_addr <= wr_next;
      end
    end
  end

  // per-lane store of each beat, masked lanes untouched
  always_ff @(posedge ref_clk) begin
    if (wr_act && wr_beat == 2'h3 && kn_r) begin
      for (int b = 0; b < qds_pkg::BEATS; b++) begin
        for (int l = 0; l < NL; l++) begin
          if (!((b == 3) ? m_s2[l] : wr_mask[b][l]))
            store[{wr_addr, 2'(b)}][l*LW +: LW] <= (b == 3) ? d_s2[l*LW +: LW]
                                                            : wr_data[b][l*LW +: LW];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // read launch through output clocks
  // ---------------------------------------------------------------------------
  logic [AW-1:0] rd_addr;
  logic [AW-1:0] rd_next;
  logic          rd_pend;
  logic          rd_act;
  logic [1:0]    rd_beat;
  // beat 0 on n side, then p, n, p
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_pend          <= 1'b0;
      rd_act           <= 1'b0;
      rd_beat          <= 2'h0;
      rd_addr          <= '0;
      rd_next          <= '0;
      lnk.rd_data_out  <= '0;
      lnk.ret_timing_p <= 1'b0;
      lnk.ret_timing_n <= 1'b1;
    end else begin
      if (out_p || out_n) begin
        lnk.ret_timing_p <= out_p;
        lnk.ret_timing_n <= out_n;
      end
      if (rd_act && ((rd_beat[0] == 1'b0) ? out_n : out_p)) begin
        lnk.rd_data_out <= store[{rd_addr, rd_beat}];
        rd_beat         <= rd_beat + 2'h1;
        if (rd_beat == 2'h3) rd_act <= 1'b0;
      end
      // a read every other k period starts as the running burst ends;
      // its address waits aside so that burst keeps its own, start wins
      if (rd_go) begin
        rd_pend <= 1'b1;
        rd_next <= a_s2;
      end else if (rd_pend && kp_r) begin
        rd_pend <= 1'b0;
        rd_act  <= 1'b1;
        rd_beat <= 2'h0;
        rd_addr <= rd_next;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // periodic impedance step
  // ---------------------------------------------------------------------------
  logic [15:0] cal_cnt;
  // cal pin high asks for a weaker setting, low for a stronger one
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cal_cnt     <= 16'h0000;
      drive_level <= qds_pkg::IMP_RST;
    end else if (cal_cnt == 16'(CAL_CYC - 1)) begin
      cal_cnt <= 16'h0000;
      if (cal_s2 && drive_level != 4'hF) drive_level <= drive_level + 4'h1;
      else if (!cal_s2 && drive_level != 4'h0) drive_level <= drive_level - 4'h1;
    end else begin
      cal_cnt <= cal_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### rtl/qds_pkg.sv
// shared constants for the burst-of-four ddr memory port and its controller
// ----------------------------------------------------------------------------
// Contract
// - address and selects sampled on input clock rise
// - both selects high means deselect
// - read starts low, ignored after a read
// - read drives four beats on output clocks
// - read select high starts read deselect
// - write low with read high starts write
// - write ignored after a previous write
// - write data taken on four alternating edges
// - lane masks sampled with each data beat
// - high mask keeps stored lane unchanged
// - masks independent per beat and lane
// - one address carries a four beat transfer
// - output registers fire on output clock pair
// - output clocks held high use input clocks
// - cycle counter periodically triggers impedance evaluation
// - impedance moves at most one step
// - controller waits 20 us after power-up
// - power-up wait only once after power-up
// - clock loop disable low turns loop off
// - 2048 stable clocks after disable released
// - loop resets on disable or 30 ns stop
// - lanes map to 9-bit data groups
// ----------------------------------------------------------------------------
`default_nettype none
package qds_pkg;
  localparam int LANE_W      = 9;
  localparam int LANES       = 2;
  localparam int DATA_W      = LANE_W * LANES;
  localparam int ADDR_W      = 8;
  localparam int BEATS       = 4;
  localparam int CLK_NS      = 10;
  localparam int KINIT_US    = 20;
  localparam int KINIT_CYC   = (KINIT_US * 1000) / CLK_NS;
  localparam int LOCK_KCYC   = 2048;
  localparam int STOP_NS     = 30;
  localparam int STOP_CYC    = (STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAL_PERIOD  = 256;
  localparam int IMP_W       = 4;
  localparam logic [3:0] IMP_RST = 4'h8;
  localparam int KDIV        = 4;
endpackage
`default_nettype wire

// ### rtl/qds_if.sv
// pin-level link between controller and memory port
`default_nettype none
interface qds_if;
  logic                           k_p;
  logic                           k_n;
  logic                           c_p;
  logic                           c_n;
  logic                           rd_sel_n;
  logic                           wr_sel_n;
  logic [qds_pkg::ADDR_W-1:0]     addr_in;
  logic [qds_pkg::DATA_W-1:0]     wr_data_in;
  logic [qds_pkg::LANES-1:0]      lane_mask_n;
  logic [qds_pkg::DATA_W-1:0]     rd_data_out;
  logic                           ret_timing_p;
  logic                           ret_timing_n;
  logic                           loop_en_n_off;
  logic                           drive_cal_pin;
  modport mem (input k_p, k_n, c_p, c_n, rd_sel_n, wr_sel_n, addr_in, wr_data_in,
               lane_mask_n, loop_en_n_off, drive_cal_pin,
               output rd_data_out, ret_timing_p, ret_timing_n);
  modport ctl (output k_p, k_n, c_p, c_n, rd_sel_n, wr_sel_n, addr_in, wr_data_in,
               lane_mask_n, loop_en_n_off, drive_cal_pin,
               input rd_data_out, ret_timing_p, ret_timing_n);
endinterface
`default_nettype wire

// ### rtl/qds_buf2.sv
// two-entry valid/ready buffer
`default_nettype none
module qds_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem [2];
  logic         wp;
  logic         rp;
  logic [1:0]   cnt;
  logic         push;
  logic         pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rp];

  // pointers and fill level
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push) wp <= ~wp;
      if (pop) rp <= ~rp;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage, no reset needed
  always_ff @(posedge ref_clk) begin
    if (push) mem[wp] <= in_data;
  end
endmodule
`default_nettype wire

// ### rtl/qds_ctl.sv
// controller end: makes the link clocks and sequences buffered requests
`default_nettype none
module qds_ctl #(
  parameter int INIT_CYC = qds_pkg::KINIT_CYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // user requests: op 1 = write
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_wr,
  input  wire logic [qds_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [4*qds_pkg::DATA_W-1:0] req_data,
  input  wire logic [4*qds_pkg::LANES-1:0]  req_mask_n,
  // read answer
  output logic                             rsp_valid,
  output logic [qds_pkg::DATA_W-1:0]       rsp_data,
  // link
  qds_if.ctl                               lnk
);
  localparam int DW = qds_pkg::DATA_W;
  localparam int NL = qds_pkg::LANES;
  localparam int RW = 1 + qds_pkg::ADDR_W + 4 * DW + 4 * NL;

  logic          b_valid;
  logic          b_ready;
  logic [RW-1:0] b_data;

  qds_buf2 #(.W(RW)) u_buf (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_wr, req_addr, req_data, req_mask_n}),
    .out_valid (b_valid),
    .out_ready (b_ready),
    .out_data  (b_data)
  );

  // ---------------------------------------------------------------------------
  // link clock divider: phase 0 k rise, phase 4 k-bar rise
  // ---------------------------------------------------------------------------
  logic [2:0]  ph;
  logic [15:0] init_cnt;
  logic        ready_go;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ph                <= 3'h0;
      lnk.k_p           <= 1'b0;
      lnk.k_n           <= 1'b1;
      lnk.c_p           <= 1'b1;
      lnk.c_n           <= 1'b1;
      lnk.loop_en_n_off <= 1'b0;
      lnk.drive_cal_pin <= 1'b0;
    end else begin
      ph                <= ph + 3'h1;
      lnk.loop_en_n_off <= 1'b1;
      if (ph == 3'h7) begin
        lnk.k_p <= 1'b1;
        lnk.k_n <= 1'b0;
      end else if (ph == 3'h3) begin
        lnk.k_p <= 1'b0;
        lnk.k_n <= 1'b1;
      end
    end
  end

  // 20 us wait once after reset; shorter than the default 2048-clock loop lock (16384 cycles)
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      init_cnt <= 16'h0000;
      ready_go <= 1'b0;
    end else if (!ready_go) begin
      init_cnt <= init_cnt + 16'h0001;
      if (init_cnt == 16'(INIT_CYC - 1)) ready_go <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // command and beat driving; one op at a time with idle k periods between, so none is ignored
  // ---------------------------------------------------------------------------
  logic       wr_run;
  logic [1:0] beat;
  logic [4*DW-1:0] wd;
  logic [4*NL-1:0] wm;
  logic       rd_wait;
  logic [4:0] rd_cnt;
  logic       cmd_slot;

  assign cmd_slot = (ph == 3'h7) && ready_go && b_valid && !wr_run && !rd_wait;
  assign b_ready  = cmd_slot;

  // command driven on the same ref edge as k rise, deselect one cycle ahead
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lnk.rd_sel_n    <= 1'b1;
      lnk.wr_sel_n    <= 1'b1;
      lnk.addr_in     <= '0;
      lnk.wr_data_in  <= '0;
      lnk.lane_mask_n <= '1;
      wr_run          <= 1'b0;
      beat            <= 2'h0;
      wd              <= '0;
      wm              <= '1;
    end else if (ph == 3'h6) begin
      lnk.rd_sel_n <= 1'b1;
      lnk.wr_sel_n <= 1'b1;
    end else if (cmd_slot) begin
      lnk.addr_in  <= b_data[RW-2 -: qds_pkg::ADDR_W];
      lnk.rd_sel_n <= b_data[RW-1];
      lnk.wr_sel_n <= !b_data[RW-1];
      if (b_data[RW-1]) begin
        wr_run <= 1'b1;
        beat   <= 2'h0;
        wd     <= b_data[4*NL +: 4*DW];
        wm     <= b_data[4*NL-1:0];
      end
      // each beat goes out two cycles before its capture edge and stays
      // two after, so a following write never overruns beat three
    end else if (wr_run && (beat[0] ? (ph == 3'h1) : (ph == 3'h5))) begin
      lnk.wr_data_in  <= wd[beat*DW +: DW];
      lnk.lane_mask_n <= wm[beat*NL +: NL];
      beat            <= beat + 2'h1;
      if (beat == 2'h3) wr_run <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // read return capture on echo clock edges
  // ---------------------------------------------------------------------------
  logic [1:0] e_s1;
  logic [1:0] e_s2;
  logic [1:0] e_d;
  logic [DW-1:0] q_s1;
  logic [DW-1:0] q_s2;
  always_ff @(posedge ref_clk) begin
    e_s1 <= {lnk.ret_timing_n, lnk.ret_timing_p};
    e_s2 <= e_s1;
    q_s1 <= lnk.rd_data_out;
    q_s2 <= q_s1;
  end

  // one captured word per echo change, the fifth to eighth after a read is issued
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      e_d       <= e_s2;  // no false echo change on release
      rd_wait   <= 1'b0;
      rd_cnt    <= 5'h00;
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      e_d       <= e_s2;
      rsp_valid <= 1'b0;
      if (cmd_slot && !b_data[RW-1]) begin
        rd_wait <= 1'b1;
        rd_cnt  <= 5'h00;
      end else if (rd_wait && e_s2 != e_d && rd_cnt >= 5'h04) begin
        rsp_valid <= 1'b1;
        rsp_data  <= q_s2;
        if (rd_cnt == 5'h07) rd_wait <= 1'b0;
        rd_cnt <= rd_cnt + 5'h01;
      end else if (rd_wait && e_s2 != e_d) begin
        rd_cnt <= rd_cnt + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/qds_link_properties.sv
// link checker for the burst-of-four memory port and its controller
`default_nettype none
module qds_link_properties #(
  parameter int CAL_CYC = 32,
  parameter int LOCK    = 16
) (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       resetn,
  // link clocks and commands
  input wire logic                       k_p,
  input wire logic                       k_n,
  input wire logic                       c_p,
  input wire logic                       c_n,
  input wire logic                       rd_sel_n,
  input wire logic                       wr_sel_n,
  input wire logic [qds_pkg::ADDR_W-1:0] addr_in,
  input wire logic [qds_pkg::DATA_W-1:0] wr_data_in,
  input wire logic [qds_pkg::LANES-1:0]  lane_mask_n,
  input wire logic                       loop_en_n_off,
  // memory answers and status
  input wire logic [qds_pkg::DATA_W-1:0] rd_data_out,
  input wire logic                       ret_timing_p,
  input wire logic                       ret_timing_n,
  input wire logic                       loop_locked,
  input wire logic [qds_pkg::IMP_W-1:0]  drive_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  int gap;
  int up;
  // cycles since the impedance level last moved; saturates, never wraps
  always_ff @(posedge ref_clk) begin
    if (!resetn || $changed(drive_level)) gap <= 0;
    else if (gap < CAL_CYC) gap <= gap + 1;
  end
  // cycles with the loop enabled; lock cannot come sooner than this allows
  always_ff @(posedge ref_clk) begin
    if (!resetn || !loop_en_n_off) up <= 0;
    else if (up < LOCK * 8) up <= up + 1;
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_one_command: assert property (rd_sel_n || wr_sel_n)
    else $error("read and write selected together");
  a_cmd_hold: assert property ($rose(k_p) |=> $stable({rd_sel_n, wr_sel_n, addr_in}))
    else $error("command moved right after input clock rise");
  a_beat_setup: assert property (($rose(k_p) || $rose(k_n)) |-> $stable({wr_data_in, lane_mask_n}))
    else $error("write beat or mask moved at capture edge");
  a_step_one: assert property (drive_level - $past(drive_level) inside {4'h0, 4'h1, 4'hF})
    else $error("impedance level jumped by more than one step");
  a_cal_spacing: assert property ($changed(drive_level) |-> gap >= CAL_CYC - 2)
    else $error("impedance evaluated before the cycle counter ran out");
  a_lock_off: assert property (!loop_en_n_off [*5] |-> !loop_locked)
    else $error("loop reported locked while disabled");
  a_lock_count: assert property ($rose(loop_locked) |-> up >= (LOCK - 2) * 8)
    else $error("loop locked too early");
  a_data_echo: assert property ($changed(rd_data_out) |-> $changed({ret_timing_p, ret_timing_n}))
    else $error("read data moved without an echo clock edge");
  a_k_fires_out: assert property (($rose(k_p) && c_p && c_n) |-> ##[1:5] $changed({ret_timing_p, ret_timing_n}))
    else $error("input clock did not fire outputs with output clocks high");
  // main scenarios
  c_read: cover property ($rose(k_p) && !rd_sel_n);
  c_write: cover property ($rose(k_p) && !wr_sel_n);
  c_locked: cover property ($rose(loop_locked));
endmodule
`default_nettype wire

// ### tb/quad_ddr_burst4_sram_port_tb.sv
// self-checking bench: controller and memory port joined over the link
`default_nettype none
module quad_ddr_burst4_sram_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [qds_pkg::DATA_W-1:0] qds_word_t;
  localparam int INIT = 300;
  localparam int LOCK = 16;
  localparam int CAL = 32;
  localparam int LIMIT = 20000;
  localparam int DW = qds_pkg::DATA_W;
  localparam int LW = qds_pkg::LANE_W;
  localparam int NL = qds_pkg::LANES;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                        ref_clk = 1'b0;
  logic                        resetn = 1'b0;
  logic                        req_valid = 1'b0;
  logic                        req_ready;
  logic                        req_wr = 1'b0;
  logic [qds_pkg::ADDR_W-1:0]  req_addr = '0;
  logic [4*DW-1:0]             req_data = '0;
  logic [4*NL-1:0]             req_mask_n = '1;
  logic                        rsp_valid;
  qds_word_t                   rsp_data;
  logic                        loop_locked;
  logic [qds_pkg::IMP_W-1:0]   drive_level;
  int                          n_fail = 0;
  int                          cmp_count = 0;
  int                          cyc = 0;
  int                          first_cmd = -1;
  logic                        lock_at_cmd;
  logic                        c_high;
  qds_word_t                   mdl [0:(4<<qds_pkg::ADDR_W)-1];
  qds_word_t                   exp_q [$];
  logic [qds_pkg::ADDR_W-1:0]  adr [4];
  qds_if lnk();
  always #5 ref_clk = ~ref_clk;
  // ---------------------------------------------------------------
  // both ends and the checker
  // ---------------------------------------------------------------
  qds_ctl #(.INIT_CYC(INIT)) qds_ctl_i (
    .ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
    .req_wr(req_wr), .req_addr(req_addr), .req_data(req_data), .req_mask_n(req_mask_n),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .lnk(lnk.ctl));
  qds_mem #(.CAL_CYC(CAL), .LOCK(LOCK)) qds_mem_i (
    .ref_clk(ref_clk), .resetn(resetn), .lnk(lnk.mem), .loop_locked(loop_locked),
    .drive_level(drive_level));
  qds_link_properties #(.CAL_CYC(CAL), .LOCK(LOCK)) qds_link_properties_i (
    .ref_clk(ref_clk), .resetn(resetn), .k_p(lnk.k_p), .k_n(lnk.k_n), .c_p(lnk.c_p),
    .c_n(lnk.c_n), .rd_sel_n(lnk.rd_sel_n), .wr_sel_n(lnk.wr_sel_n), .addr_in(lnk.addr_in),
    .wr_data_in(lnk.wr_data_in), .lane_mask_n(lnk.lane_mask_n),
    .loop_en_n_off(lnk.loop_en_n_off), .rd_data_out(lnk.rd_data_out),
    .ret_timing_p(lnk.ret_timing_p), .ret_timing_n(lnk.ret_timing_n),
    .loop_locked(loop_locked), .drive_level(drive_level));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input qds_word_t exp, input qds_word_t got);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [95:0] rnd();
    return {$urandom, $urandom, $urandom};
  endfunction
  // offer one request until taken, then mirror it in the model;
  // valid is left high so back-to-back calls never toggle it in one step
  task automatic send(input logic wr, input logic [qds_pkg::ADDR_W-1:0] a,
                      input logic [4*DW-1:0] d, input logic [4*NL-1:0] m);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_wr = wr;
    req_addr = a;
    req_data = d;
    req_mask_n = m;
    while (req_ready !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 1000) n_fail++;
    @(posedge ref_clk);
    #1;
    // a masked lane keeps the old word; reads snapshot the model in order
    for (int b = 0; b < 4; b++) begin
      if (!wr) exp_q.push_back(mdl[a * 4 + b]);
      for (int l = 0; l < NL; l++) begin
        if (wr && !m[b * NL + l]) mdl[a * 4 + b][l * LW +: LW] = d[b * DW + l * LW +: LW];
      end
    end
  endtask
  // ---------------------------------------------------------------
  // monitors
  // ---------------------------------------------------------------
  // every read beat is compared with the model in issue order
  always @(posedge ref_clk) begin
    if (resetn && rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        $display("wrong value read beat: expected none, seen %h", rsp_data);
        n_fail++;
      end
      else check("read beat", exp_q.pop_front(), rsp_data);
    end
  end
  // first command on the wire, and the hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (first_cmd < 0 && resetn && (lnk.rd_sel_n === 1'b0 || lnk.wr_sel_n === 1'b0)) begin
      first_cmd = cyc;
      lock_at_cmd = loop_locked;
      c_high = lnk.c_p & lnk.c_n;
    end
    if (cyc == LIMIT) begin
      n_fail++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [95:0] r;
    int n;
    void'($urandom(32'h5F66FF29));
    r = rnd();
    adr[0] = '0;
    adr[1] = '1;
    adr[2] = r[qds_pkg::ADDR_W-1:0];
    adr[3] = r[32 +: qds_pkg::ADDR_W];
    repeat (10) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    // fill the four bursts unmasked, then read them back to back
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      send(1'b1, adr[i], r[4*DW-1:0], 8'h00);
    end
    for (int i = 0; i < 4; i++) send(1'b0, adr[i], '0, '1);
    // per-beat lane pattern, then a fully masked write
    r = rnd();
    send(1'b1, adr[1], r[4*DW-1:0], 8'h46);
    r = rnd();
    send(1'b1, adr[2], r[4*DW-1:0], 8'hFF);
    send(1'b0, adr[1], '0, '1);
    send(1'b0, adr[2], '0, '1);
    // random mix of reads and masked writes, back-to-back writes included
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      send(1'($urandom % 2), adr[$urandom % 4], r[4*DW-1:0], r[95 -: 4*NL]);
    end
    send(1'b0, adr[3], '0, '1);
    req_valid = 1'b0;
    n = 0;
    while (exp_q.size() > 0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    check("beats left", '0, qds_word_t'(exp_q.size()));
    check("init wait", qds_word_t'(1), qds_word_t'(first_cmd >= INIT + 10));
    check("lock at first command", qds_word_t'(1), qds_word_t'(lock_at_cmd));
    check("output clocks high", qds_word_t'(1), qds_word_t'(c_high));
    wrap_up();
  end
endmodule
`default_nettype wire
